// File: cmsd_pkg.sv
// Package for the channel/mode select decoder: widths, table layout, timing.
// Assumes one core clock domain at 250 MHz and active-low async reset.
`default_nettype none
package cmsd_pkg;
    localparam int DATA_W       = 4;
    localparam int FREQ_W       = 3;
    localparam int PROF_W       = 2;
    localparam int CHAN_W       = 4;
    localparam int NUM_PROF     = 4;
    localparam int NUM_BANK_CH  = 8;
    localparam int NUM_CH       = 16;
    localparam int DEV_W        = 16;
    localparam int OFS_W        = 16;
    localparam int CFREQ_W      = 32;
    localparam int SET_IDX_W    = 5;
    localparam int CLK_MHZ      = 250;
    // Synthesizer relock allowance after a channel change
    localparam int LOCK_TIME_US = 10;
    localparam int LOCK_CYC     = LOCK_TIME_US * CLK_MHZ;
    localparam int LOCK_CNT_W   = 13;
    localparam logic [PROF_W-1:0] PROF_A = 2'h0;
    localparam logic [PROF_W-1:0] PROF_B = 2'h1;
    localparam logic [PROF_W-1:0] PROF_C = 2'h2;
    localparam logic [PROF_W-1:0] PROF_D = 2'h3;
    // Software register offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK   = 4'h1;
    localparam logic [3:0] REG_CTRL   = 4'h2;
    localparam logic [3:0] REG_SEL    = 4'h3;
    localparam logic [3:0] REG_WADDR  = 4'h4;
    localparam logic [3:0] REG_WDEV   = 4'h5;
    localparam logic [3:0] REG_WOFS   = 4'h6;
    localparam logic [3:0] REG_WCFREQ = 4'h7;
    // Status bits
    localparam int ST_PROF_CHG = 0;
    localparam int ST_CH_CHG   = 1;
    localparam int ST_FAULT    = 2;
    localparam int ST_W        = 3;
    // Control bits
    localparam int CT_ALT_BOARD = 0;
    localparam int CT_SERIAL    = 1;
    localparam int CT_HIGH_RATE = 2;
    localparam int CT_KEY       = 3;
endpackage
`default_nettype wire

// File: cmsd_if.sv
// Parallel select lines from transmitter controller to exciter interface board.
// Lines are plain levels; device synchronises them.
`default_nettype none
interface cmsd_if;
    logic [3:0] data_in;
    logic [1:0] mode_in;
    logic [2:0] freq_in;
    logic       key_in;
    logic       key_ind;
    logic       fault_out;
    modport ctl (output data_in, output mode_in, output freq_in, output key_in,
                 input key_ind, input fault_out);
    modport dev (input data_in, input mode_in, input freq_in, input key_in,
                 output key_ind, output fault_out);
endinterface
`default_nettype wire

// File: cmsd_device.sv
// Exciter end: interface-board remap, profile/channel decode, settings lookup.
// Assumes controller lines are asynchronous to core_clk; one core clock.
// Function
// - Four profiles each with deviation and offset
// - Data lines three and four pick profile
// - Profile change applied live, no relock
// - Controller unkeys in the same cycle as channel change
// - Alternate board: profile D only
// - Controller early pairing: high-rate picks B, else A
// - Only eight channels store profile settings
// - Bank line low selects channels 9-16
// - Deviation and offset settings mirror lower bank
// - Sixteen separate center frequencies
// - Upper bank only in serial mode
// - Data inputs 0-3 drive outputs 1-4
// - Mode0 to profile bit, mode1 to bank
// - Freq inputs 0-2 drive channel bits 0-2
// - Fault unkeys RF output
`default_nettype none
module cmsd_device
    import cmsd_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Controller lines
    cmsd_if.dev                      lnk,
    // Fault sources
    input  wire logic                fault_in,
    // Software port
    input  wire logic [3:0]          sw_addr,
    input  wire logic [31:0]         sw_wdata,
    input  wire logic                sw_wr,
    input  wire logic                sw_rd,
    output logic      [31:0]         sw_rdata,
    // Settings to modulator and synthesizer
    output logic      [DEV_W-1:0]    deviation_out,
    output logic      [OFS_W-1:0]    offset_out,
    output logic      [CFREQ_W-1:0]  center_freq_out,
    output logic                     rf_key_out,
    output logic                     irq
);
    typedef enum logic [2:0] {
        CMSD_IDLE = 3'b001,
        CMSD_LOCK = 3'b010,
        CMSD_ON   = 3'b100
    } cmsd_key_t;

    logic [DATA_W-1:0] data_s1_r, data_s2_r;
    logic [1:0]        mode_s1_r, mode_s2_r;
    logic [FREQ_W-1:0] freq_s1_r, freq_s2_r;
    logic              key_s1_r, key_s2_r, flt_s1_r, flt_s2_r;
    logic [DEV_W-1:0]  dev_mem_r  [NUM_BANK_CH*NUM_PROF];
    logic [OFS_W-1:0]  ofs_mem_r  [NUM_BANK_CH*NUM_PROF];
    logic [CFREQ_W-1:0] cf_mem_r  [NUM_CH];
    logic [SET_IDX_W-1:0] waddr_r;
    logic [ST_W-1:0]   status_r, mask_r;
    logic [3:0]        ctrl_r;
    logic [CHAN_W-1:0] chan_r;
    logic [PROF_W-1:0] prof_r;
    logic [LOCK_CNT_W-1:0] lock_cnt_r;
    cmsd_key_t         key_st_r;
    logic [4:1]        data_int;
    logic              mode_sel1, upper_bank_select_out;
    logic [FREQ_W-1:0] channel_bits;
    logic              channel_bit0_out;
    logic [PROF_W-1:0] prof_req;
    logic [CHAN_W-1:0] chan_req;
    logic              live_profile_switch, ch_chg;

    // Two-flop synchronisers on all controller and fault pins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_s1_r <= '0; data_s2_r <= '0;
            mode_s1_r <= 2'h3; mode_s2_r <= 2'h3;
            freq_s1_r <= '0; freq_s2_r <= '0;
            key_s1_r  <= 1'b0; key_s2_r <= 1'b0;
            flt_s1_r  <= 1'b0; flt_s2_r <= 1'b0;
        end else begin
            data_s1_r <= lnk.data_in; data_s2_r <= data_s1_r;
            mode_s1_r <= lnk.mode_in; mode_s2_r <= mode_s1_r;
            freq_s1_r <= lnk.freq_in; freq_s2_r <= freq_s1_r;
            key_s1_r  <= lnk.key_in;  key_s2_r  <= key_s1_r;
            flt_s1_r  <= fault_in;    flt_s2_r  <= flt_s1_r;
        end
    end

    // Interface board remap
    always_comb begin
        data_int              = data_s2_r;
        mode_sel1             = mode_s2_r[0];
        upper_bank_select_out = ~mode_s2_r[1];
        channel_bits          = freq_s2_r;
        channel_bit0_out      = channel_bits[0];
    end

    // Profile from data lines 3 and 4; alternate board forces D
    always_comb begin
        prof_req = ctrl_r[CT_ALT_BOARD] ? PROF_D : data_int[4:3];
        chan_req = {upper_bank_select_out, channel_bits[2:1], channel_bit0_out};
        live_profile_switch = (prof_req != prof_r) && (chan_req == chan_r);
        ch_chg   = (chan_req != chan_r);
    end

    function automatic logic [SET_IDX_W-1:0] set_idx(input logic [CHAN_W-1:0] ch,
                                                     input logic [PROF_W-1:0] pr);
        set_idx = {ch[2:0], pr};
    endfunction

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_r <= '0;
            prof_r <= PROF_A;
        end else begin
            chan_r <= chan_req;
            prof_r <= prof_req;
        end
    end

    // Key control: channel change forces relock wait, profile change does not
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            key_st_r   <= CMSD_LOCK;
            lock_cnt_r <= '0;
        end else begin
            case (key_st_r)
                CMSD_IDLE: if (ch_chg) begin
                    key_st_r   <= CMSD_LOCK;
                    lock_cnt_r <= '0;
                end else if (key_s2_r && !flt_s2_r && ctrl_r[CT_KEY]) begin
                    key_st_r <= CMSD_ON;
                end
                CMSD_LOCK: if (ch_chg) begin
                    lock_cnt_r <= '0;
                end else if (lock_cnt_r == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                    key_st_r <= CMSD_IDLE;
                end else begin
                    lock_cnt_r <= lock_cnt_r + 1'b1;
                end
                CMSD_ON: if (ch_chg) begin
                    key_st_r   <= CMSD_LOCK;
                    lock_cnt_r <= '0;
                end else if (flt_s2_r || !key_s2_r || !ctrl_r[CT_KEY]) begin
                    key_st_r <= CMSD_IDLE;
                end
                default: key_st_r <= CMSD_LOCK;
            endcase
        end
    end

    // Output settings, profile swaps land without touching the key
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            deviation_out   <= '0;
            offset_out      <= '0;
            center_freq_out <= '0;
            rf_key_out      <= 1'b0;
            lnk.key_ind     <= 1'b0;
            lnk.fault_out   <= 1'b0;
        end else begin
            deviation_out   <= dev_mem_r[set_idx(chan_r, prof_r)];
            offset_out      <= ofs_mem_r[set_idx(chan_r, prof_r)];
            center_freq_out <= cf_mem_r[chan_r];
            rf_key_out      <= (key_st_r == CMSD_ON) && !flt_s2_r;
            lnk.key_ind     <= (key_st_r == CMSD_ON) && !flt_s2_r;
            lnk.fault_out   <= flt_s2_r;
        end
    end

    // Settings storage written by software
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waddr_r <= '0;
            for (int i = 0; i < NUM_BANK_CH*NUM_PROF; i++) begin
                dev_mem_r[i] <= '0;
                ofs_mem_r[i] <= '0;
            end
            for (int i = 0; i < NUM_CH; i++) cf_mem_r[i] <= '0;
        end else if (sw_wr) begin
            case (sw_addr)
                REG_WADDR:  waddr_r <= sw_wdata[SET_IDX_W-1:0];
                REG_WDEV:   dev_mem_r[waddr_r] <= sw_wdata[DEV_W-1:0];
                REG_WOFS:   ofs_mem_r[waddr_r] <= sw_wdata[OFS_W-1:0];
                REG_WCFREQ: cf_mem_r[waddr_r[CHAN_W-1:0]] <= sw_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= '0;
            mask_r <= '0;
        end else if (sw_wr) begin
            if (sw_addr == REG_CTRL) ctrl_r <= sw_wdata[3:0];
            if (sw_addr == REG_MASK) mask_r <= sw_wdata[ST_W-1:0];
        end
    end

    // Sticky status: a new event wins over a same-cycle clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~((sw_wr && sw_addr == REG_STATUS)
                                      ? sw_wdata[ST_W-1:0] : '0))
                        | {flt_s2_r, ch_chg, live_profile_switch};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq      <= 1'b0;
            sw_rdata <= '0;
        end else begin
            irq <= |(status_r & mask_r);
            if (sw_rd) begin
                case (sw_addr)
                    REG_STATUS: sw_rdata <= 32'(status_r);
                    REG_MASK:   sw_rdata <= 32'(mask_r);
                    REG_CTRL:   sw_rdata <= 32'(ctrl_r);
                    REG_SEL:    sw_rdata <= 32'({mode_sel1, key_st_r, prof_r, chan_r});
                    REG_WADDR:  sw_rdata <= 32'(waddr_r);
                    default:    sw_rdata <= '0;
                endcase
            end else begin
                sw_rdata <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// File: cmsd_ctrl.sv
// Controller end: drives select lines, unkeys around channel changes.
// Assumes user requests on core_clk; key_ind returns asynchronously.
`default_nettype none
module cmsd_ctrl
    import cmsd_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Controller lines
    cmsd_if.ctl                      lnk,
    // User side
    input  wire logic                req_valid,
    input  wire logic [CHAN_W-1:0]   req_chan,
    input  wire logic [PROF_W-1:0]   req_prof,
    input  wire logic                high_rate,
    input  wire logic                early_pairing,
    input  wire logic                serial_mode,
    input  wire logic                key_req,
    input  wire logic [1:0]          aux_data,
    output logic                     busy,
    output logic                     keyed
);
    logic [CHAN_W-1:0]     chan_r;
    logic [PROF_W-1:0]     prof_r;
    logic [LOCK_CNT_W-1:0] wait_r;
    logic                  ki_s1_r, ki_s2_r;
    logic [CHAN_W-1:0]     chan_ok;

    // Upper bank only reachable in serial mode
    assign chan_ok = serial_mode ? req_chan : {1'b0, req_chan[2:0]};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_r <= '0;
            prof_r <= PROF_A;
            wait_r <= '0;
        end else begin
            if (wait_r != '0) wait_r <= wait_r - 1'b1;
            if (req_valid && wait_r == '0) begin
                if (chan_ok != chan_r) begin
                    chan_r <= chan_ok;
                    wait_r <= LOCK_CNT_W'(LOCK_CYCLES + 4);
                end
                prof_r <= early_pairing ? (high_rate ? PROF_B : PROF_A) : req_prof;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lnk.data_in <= '0;
            lnk.mode_in <= 2'h3;
            lnk.freq_in <= '0;
            lnk.key_in  <= 1'b0;
            ki_s1_r     <= 1'b0;
            ki_s2_r     <= 1'b0;
            busy        <= 1'b0;
            keyed       <= 1'b0;
        end else begin
            lnk.data_in <= {prof_r, aux_data};
            lnk.mode_in <= {~chan_r[3], prof_r[0]};
            lnk.freq_in <= chan_r[2:0];
            lnk.key_in  <= key_req && wait_r == '0;
            ki_s1_r     <= lnk.key_ind;
            ki_s2_r     <= ki_s1_r;
            keyed       <= ki_s2_r;
            busy        <= wait_r != '0;
        end
    end
endmodule
`default_nettype wire

// File: cmsd_properties.sv
// Checker on the select lines between the controller and the device ends.
// Sees only the link signals plus the core clock and reset from the bench.
`default_nettype none
module cmsd_properties (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       nrst,
    // Link lines
    input wire logic [3:0] data_in,
    input wire logic [1:0] mode_in,
    input wire logic [2:0] freq_in,
    input wire logic       key_in,
    input wire logic       key_ind,
    input wire logic       fault_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    logic [3:0] chan_r;
    logic [3:0] quiet_r;
    // Cycles since the last bank or channel change, saturating
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_r  <= 4'h8;
            quiet_r <= 4'h0;
        end else begin
            chan_r <= {mode_in[1], freq_in};
            if (chan_r != {mode_in[1], freq_in}) quiet_r <= 4'h0;
            else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
        end
    end
    a_unkey_on_chan: assert property ($changed(freq_in) |-> !key_in)
        else $error("channel changed while keyed");
    a_unkey_on_bank: assert property ($changed(mode_in[1]) |-> !key_in)
        else $error("bank changed while keyed");
    a_chan_quiet: assert property ($changed({mode_in[1], freq_in}) |-> !key_in [*8])
        else $error("key request during relock");
    a_rekey_wait: assert property ($rose(key_in) |-> quiet_r >= 4'h8)
        else $error("keyed too soon after channel change");
    a_chan_unkeys: assert property ($changed({mode_in[1], freq_in}) |-> ##[1:5] !key_ind)
        else $error("device still keyed after channel change");
    a_live_keep: assert property ($changed(data_in[3:2]) && $stable({mode_in[1], freq_in})
        && key_in && key_ind && !fault_out |-> ##1 key_ind [*4])
        else $error("profile change dropped the key");
    a_fault_unkeys: assert property (fault_out |-> ##[0:2] !key_ind)
        else $error("keyed during fault");
    a_no_req_key: assert property (!key_in [*6] |-> !key_ind)
        else $error("keyed without request");
    cover property ($changed(data_in[3:2]) && key_ind);
    cover property (!mode_in[1] && key_ind);
    cover property ($rose(fault_out));
endmodule
`default_nettype wire

// File: tb.sv
// Bench joining the controller and device ends over the select-line interface.
// Drives the software port and user side from one 250 MHz clock.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cmsd_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, fault_in = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
    logic req_valid = 1'b0, high_rate = 1'b0, early_pairing = 1'b0, serial_mode = 1'b1;
    logic key_req = 1'b0, rf_key_out, irq, busy, keyed;
    logic [3:0]         sw_addr = 4'h0;
    logic [31:0]        sw_wdata = 32'h0, sw_rdata;
    logic [CHAN_W-1:0]  req_chan = 4'h0;
    logic [PROF_W-1:0]  req_prof = 2'h0;
    logic [1:0]         aux_data = 2'h1;
    logic [DEV_W-1:0]   deviation_out;
    logic [OFS_W-1:0]   offset_out;
    logic [CFREQ_W-1:0] center_freq_out;
    int mismatches = 0, n_compared = 0, cyc = 0;
    cmsd_if u_cmsd_if ();
    // Short relock keeps the run brief
    cmsd_device #(.LOCK_CYCLES(8)) u_cmsd_device (.core_clk, .nrst, .lnk(u_cmsd_if),
        .fault_in, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .deviation_out,
        .offset_out, .center_freq_out, .rf_key_out, .irq);
    cmsd_ctrl #(.LOCK_CYCLES(8)) u_cmsd_ctrl (.core_clk, .nrst, .lnk(u_cmsd_if),
        .req_valid, .req_chan, .req_prof, .high_rate, .early_pairing, .serial_mode,
        .key_req, .aux_data, .busy, .keyed);
    cmsd_properties u_props (.core_clk, .nrst, .data_in(u_cmsd_if.data_in),
        .mode_in(u_cmsd_if.mode_in), .freq_in(u_cmsd_if.freq_in),
        .key_in(u_cmsd_if.key_in), .key_ind(u_cmsd_if.key_ind),
        .fault_out(u_cmsd_if.fault_out));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1 check(sw_rdata & m, exp);
    endtask
    // Request, wait out the relock handshake, then let the sync stages settle
    task automatic go(input logic [3:0] ch, input logic [1:0] pr, input int extra);
        int n;
        @(posedge core_clk);
        req_chan <= ch;
        req_prof <= pr;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        repeat (2) @(posedge core_clk);
        while (busy !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        repeat (10 + extra) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(REG_STATUS, 32'hFFFFFFFF, 32'h0);
        check({31'h0, irq}, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(REG_WADDR, {27'h0, 3'h2, p[1:0]});
            wr(REG_WDEV, 32'h1000 + p);
            wr(REG_WOFS, 32'h2000 + p);
        end
        wr(REG_WADDR, 32'h2);
        wr(REG_WCFREQ, 32'hC002);
        wr(REG_WADDR, 32'hA);
        wr(REG_WCFREQ, 32'hC00A);
        wr(REG_CTRL, 32'hA);
        wr(REG_MASK, 32'h7);
        rd(REG_CTRL, 32'hF, 32'hA);
        rd(REG_MASK, 32'h7, 32'h7);
        rd(REG_WADDR, 32'h1F, 32'hA);
        go(4'h2, PROF_A, 0);
        key_req <= 1'b1;
        go(4'h2, PROF_A, 10);
        for (int p = 0; p < 4; p++) begin
            go(4'h2, p[1:0], 0);
            check({16'h0, deviation_out}, 32'h1000 + p);
            check({16'h0, offset_out}, 32'h2000 + p);
            check({31'h0, rf_key_out}, 32'h1);
            check(center_freq_out, 32'hC002);
            rd(REG_SEL, 32'h3F, {26'h0, p[1:0], 4'h2});
            rd(REG_SEL, 32'h200, {22'h0, p[0], 9'h0});
            check({31'h0, keyed}, 32'h1);
        end
        $display("test live profile done");
        check({31'h0, irq}, 32'h1);
        rd(REG_STATUS, 32'h3, 32'h3);
        wr(REG_STATUS, 32'h3);
        rd(REG_STATUS, 32'h7, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        go(4'hA, PROF_B, 10);
        check({31'h0, u_cmsd_if.mode_in[1]}, 32'h0);
        check({16'h0, deviation_out}, 32'h1001);
        check({16'h0, offset_out}, 32'h2001);
        check(center_freq_out, 32'hC00A);
        check({31'h0, rf_key_out}, 32'h1);
        check({31'h0, busy}, 32'h0);
        rd(REG_SEL, 32'hF, 32'hA);
        $display("test upper bank done");
        wr(REG_CTRL, 32'hB);
        go(4'h2, PROF_A, 10);
        check({16'h0, deviation_out}, 32'h1003);
        wr(REG_CTRL, 32'hA);
        early_pairing <= 1'b1;
        high_rate <= 1'b1;
        go(4'h2, PROF_C, 0);
        check({30'h0, u_cmsd_if.data_in[3:2]}, {30'h0, PROF_B});
        high_rate <= 1'b0;
        go(4'h2, PROF_C, 0);
        check({30'h0, u_cmsd_if.data_in[3:2]}, {30'h0, PROF_A});
        early_pairing <= 1'b0;
        serial_mode <= 1'b0;
        go(4'hA, PROF_A, 0);
        check({31'h0, u_cmsd_if.mode_in[1]}, 32'h1);
        serial_mode <= 1'b1;
        $display("test modes done");
        wr(REG_STATUS, 32'h7);
        wr(REG_MASK, 32'h0);
        fault_in <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1 check({31'h0, rf_key_out}, 32'h0);
        check({31'h0, u_cmsd_if.fault_out}, 32'h1);
        check({31'h0, keyed}, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd(REG_STATUS, 32'h4, 32'h4);
        wr(REG_MASK, 32'h4);
        repeat (2) @(posedge core_clk);
        #1 check({31'h0, irq}, 32'h1);
        @(posedge core_clk);
        fault_in <= 1'b0;
        repeat (8) @(posedge core_clk);
        wr(REG_STATUS, 32'h4);
        rd(4'hF, 32'hFFFFFFFF, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        $display("test fault and irq done");
        conclude();
    end
endmodule
`default_nettype wire
